/* rtl/dbdc_bus.sv */
// Bus cycle sequencer for a demultiplexed external bus with deferred cycles.
// Assumes requests come from core logic on clk_sys and per-select wait
// counts are supplied as a flat vector by the chip-select configuration.
`timescale 1ns/1ps
module dbdc_bus (
    input  wire logic                                          clk_sys,
    input  wire logic                                          rst,
    input  wire logic                                          req_valid,
    output logic                                               req_ready,
    input  wire logic                                          req_write,
    input  wire logic [dbdc_pkg::ADDR_W-1:0]                   req_addr,
    input  wire logic [dbdc_pkg::DATA_W-1:0]                   req_wdata,
    input  wire logic                                          req_high_byte,
    input  wire logic                                          req_fetch,
    input  wire logic [dbdc_pkg::SEL_W-1:0]                    req_select,
    input  wire logic [dbdc_pkg::NUM_SELECTS*dbdc_pkg::WAIT_W-1:0] per_select_bus_config,
    output logic                                               rsp_valid,
    output logic [dbdc_pkg::DATA_W-1:0]                        rsp_rdata,
    output logic                                               clock_output,
    output logic                                               ale,
    output logic                                               rd_n,
    output logic                                               wr_n,
    output logic [dbdc_pkg::NUM_SELECTS-1:0]                   chip_select_n,
    output logic [dbdc_pkg::ADDR_W-1:0]                        addr,
    output logic [dbdc_pkg::DATA_W-1:0]                        data_out,
    output logic                                               data_oe,
    input  wire logic [dbdc_pkg::DATA_W-1:0]                   data_in,
    output logic                                               high_byte_enable_n,
    output logic                                               fetch_indicator,
    input  wire logic                                          ready
);
    dbdc_pkg::dbdc_state_e           state;
    logic                            phase;
    logic [dbdc_pkg::WAIT_W-1:0]     wait_left;
    logic [dbdc_pkg::SEL_W-1:0]      last_select;
    logic                            last_was_read;
    logic                            cur_write;
    logic                            defer_pending;
    logic                            ready_sync;
    logic [dbdc_pkg::WAIT_W-1:0]     sel_wait;
    logic [dbdc_pkg::NUM_SELECTS-1:0] next_cs_n;
    logic                            take;
    logic                            state_end;

    dbdc_sync u_ready_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (ready),
        .level   (ready_sync)
    );

    // Wait count of the select being started
    always_comb begin
        sel_wait = dbdc_pkg::WAIT_RST;
        if (req_select < dbdc_pkg::SEL_W'(dbdc_pkg::NUM_SELECTS)) begin
            sel_wait = per_select_bus_config[req_select*dbdc_pkg::WAIT_W +:
                                             dbdc_pkg::WAIT_W];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < dbdc_pkg::NUM_SELECTS; gi++) begin : g_cs
            assign next_cs_n[gi] = (req_select != dbdc_pkg::SEL_W'(gi));
        end
    endgenerate

    assign req_ready = (state == dbdc_pkg::DBDC_IDLE);
    assign take      = req_valid && req_ready;
    assign state_end = phase;

    // Clock output toggles every t, giving a 2t period
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase        <= 1'b0;
            clock_output <= 1'b0;
        end else if (state == dbdc_pkg::DBDC_IDLE && !take) begin
            phase        <= 1'b0;
            clock_output <= 1'b0;
        end else begin
            phase        <= ~phase;
            clock_output <= ~phase;
        end
    end

    // Cycle sequencing
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state     <= dbdc_pkg::DBDC_IDLE;
            wait_left <= dbdc_pkg::WAIT_RST;
        end else begin
            case (state)
                dbdc_pkg::DBDC_IDLE: begin
                    if (take) begin
                        state     <= dbdc_pkg::DBDC_ADDR;
                        wait_left <= sel_wait;
                    end
                end
                dbdc_pkg::DBDC_ADDR: begin
                    if (state_end) begin
                        // One extra state for either trigger, never two
                        state <= defer_pending ? dbdc_pkg::DBDC_DEFER
                                               : dbdc_pkg::DBDC_STRB;
                    end
                end
                dbdc_pkg::DBDC_DEFER: begin
                    if (state_end) begin
                        state <= dbdc_pkg::DBDC_STRB;
                    end
                end
                dbdc_pkg::DBDC_STRB: begin
                    if (state_end) begin
                        if (wait_left != dbdc_pkg::WAIT_RST) begin
                            state <= dbdc_pkg::DBDC_WAIT;
                        end else if (!ready_sync) begin
                            state <= dbdc_pkg::DBDC_RDY;
                        end else begin
                            state <= dbdc_pkg::DBDC_IDLE;
                        end
                    end
                end
                dbdc_pkg::DBDC_WAIT: begin
                    if (state_end) begin
                        wait_left <= wait_left - 4'h1;
                        if (wait_left == 4'h1) begin
                            // Ready is only looked at once programmed waits run out
                            state <= ready_sync ? dbdc_pkg::DBDC_IDLE
                                                : dbdc_pkg::DBDC_RDY;
                        end
                    end
                end
                dbdc_pkg::DBDC_RDY: begin
                    if (state_end && ready_sync) begin
                        state <= dbdc_pkg::DBDC_IDLE;
                    end
                end
                default: begin
                    state <= dbdc_pkg::DBDC_IDLE;
                end
            endcase
        end
    end

    // Deferral triggers, judged against the previous cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_select   <= dbdc_pkg::SEL_NONE;
            last_was_read <= 1'b0;
            defer_pending <= 1'b0;
            cur_write     <= 1'b0;
        end else if (take) begin
            defer_pending <= (req_select != last_select) ||
                             (req_write && last_was_read);
            last_select   <= req_select;
            last_was_read <= !req_write;
            cur_write     <= req_write;
        end
    end

    // Address, select and data held for the whole cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr               <= '0;
            chip_select_n      <= '1;
            data_out           <= '0;
            high_byte_enable_n <= 1'b1;
            fetch_indicator    <= 1'b0;
        end else if (take) begin
            addr               <= req_addr;
            chip_select_n      <= next_cs_n;
            data_out           <= req_wdata;
            high_byte_enable_n <= !req_high_byte;
            fetch_indicator    <= req_fetch;
        end
    end

    // Strobes; read and write strobes both wait out the deferral state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ale     <= 1'b0;
            rd_n    <= 1'b1;
            wr_n    <= 1'b1;
            data_oe <= 1'b0;
        end else begin
            ale <= take;
            if (state == dbdc_pkg::DBDC_ADDR && state_end && !defer_pending) begin
                rd_n <= cur_write;
                wr_n <= !cur_write;
            end else if (state == dbdc_pkg::DBDC_DEFER && state_end) begin
                rd_n <= cur_write;
                wr_n <= !cur_write;
            end else if (state == dbdc_pkg::DBDC_IDLE) begin
                rd_n <= 1'b1;
                wr_n <= 1'b1;
            end
            if (take) begin
                data_oe <= req_write;
            end else if (state == dbdc_pkg::DBDC_IDLE) begin
                data_oe <= 1'b0;
            end
        end
    end

    // Read data captured at the end of the cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_end && ((state == dbdc_pkg::DBDC_STRB && wait_left == 4'h0 && ready_sync) ||
                (state == dbdc_pkg::DBDC_WAIT && wait_left == 4'h1 && ready_sync) ||
                (state == dbdc_pkg::DBDC_RDY && ready_sync))) begin
                rsp_valid <= 1'b1;
                if (!cur_write) begin
                    rsp_rdata <= data_in;
                end
            end
        end
    end
endmodule

/* rtl/dbdc_pkg.sv */
// Shared constants for the demultiplexed bus cycle sequencer.
// Assumes one 100 MHz system clock; one bus state is two clock periods.
package dbdc_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned STATE_T         = 2;   // One state, in periods t
    localparam int unsigned STATE_CYCLES    = STATE_T;
    localparam int unsigned BASE_STATES     = 2;   // Normal cycle is 4t
    localparam int unsigned NUM_SELECTS     = 6;
    localparam int unsigned SEL_W           = 3;
    localparam int unsigned WAIT_W          = 4;
    localparam int unsigned ADDR_W          = 20;
    localparam int unsigned DATA_W          = 16;
    localparam int unsigned SYNC_STAGES     = 3;
    localparam logic [SEL_W-1:0] SEL_NONE   = 3'h7;
    localparam logic [WAIT_W-1:0] WAIT_RST  = 4'h0;

    typedef enum logic [2:0] {
        DBDC_IDLE  = 3'b000,
        DBDC_ADDR  = 3'b001,
        DBDC_DEFER = 3'b010,
        DBDC_STRB  = 3'b011,
        DBDC_WAIT  = 3'b100,
        DBDC_RDY   = 3'b101
    } dbdc_state_e;
endpackage

/* rtl/dbdc_sync.sv */
// Three-stage synchroniser with agreement filter for the ready pin.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/1ps
module dbdc_sync (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);
    logic [2:0] stage;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // Idle level of ready, so no false stall follows reset
            stage <= 3'h7;
        end else begin
            stage <= {stage[1:0], pin};
        end
    end

    // Only stages two and three are compared; stage one feeds stage two alone
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            level <= 1'b1;
        end else if (stage[1] == stage[2]) begin
            level <= stage[2];
        end
    end
endmodule

/* tb/dbdc_bus_props.sv */
// Port checker for the bus sequencer: strobes, cycle length, deferral.
// Assumes ready drops only where a wait state is programmed.
`timescale 1ns/1ps
module dbdc_bus_props (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire logic [2:0]  req_select,
    input wire logic [23:0] per_select_bus_config,
    input wire logic        rsp_valid,
    input wire logic        clock_output,
    input wire logic        ale,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic        ready
);
    logic [7:0] cnt;
    logic [7:0] exp_n;
    logic [2:0] last_sel;
    logic       last_rd;
    logic       dfr;
    logic       stl;
    wire        take    = req_valid && req_ready;
    wire [3:0]  wt      = (req_select < 3'h6) ? per_select_bus_config[req_select*4 +: 4] : 4'h0;
    wire        new_dfr = (req_select != last_sel) || (req_write && last_rd);

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_sel <= 3'h7;
            last_rd  <= 1'b0;
            dfr      <= 1'b0;
            exp_n    <= 8'h00;
        end else if (take) begin
            last_sel <= req_select;
            last_rd  <= !req_write;
            dfr      <= new_dfr;
            exp_n    <= 8'h04 + {6'h00, new_dfr, 1'b0} + {3'h0, wt, 1'b0};
        end
    end

    // Counts from the accepting edge; stl marks cycles stretched by ready
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            stl <= 1'b0;
        end else if (take) begin
            cnt <= 8'h01;
            stl <= 1'b0;
        end else begin
            cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
            stl <= stl || !ready;
        end
    end

    ale_after_take_a:
        assert property (take |=> ale) else $error("ale missing after take");
    ale_single_a:
        assert property (ale |=> !ale) else $error("ale longer than one cycle");
    strobe_excl_a:
        assert property (!wr_n |-> rd_n) else $error("both strobes low");
    cycle_len_a:
        assert property (rsp_valid && !stl |-> cnt == exp_n) else $error("cycle length wrong");
    ready_stretch_a:
        assert property (rsp_valid && stl |-> cnt > exp_n) else $error("ready did not stretch");
    // Strobe falls one state after acceptance, or one state later when deferred
    wr_deferred_a:
        assert property ($fell(wr_n) && dfr |-> cnt == 8'h04) else $error("write strobe early");
    wr_prompt_a:
        assert property ($fell(wr_n) && !dfr |-> cnt == 8'h02) else $error("write strobe late");
    // A new request may be taken while the response pulse stands
    next_cycle_a:
        assert property (rsp_valid |-> req_ready) else $error("no idle after response");
    clk_toggle_a:
        assert property (!req_ready && !$past(req_ready) |-> clock_output != $past(clock_output))
            else $error("clock output stuck while busy");
endmodule

/* tb/dbdc_mem.sv */
// Memory-side model: returns read data, keeps write data, stalls ready.
// Assumes the bench programs a wait state wherever it asks for stalls.
`timescale 1ns/1ps
module dbdc_mem (
    input  wire logic        clk_sys,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [19:0] addr,
    input  wire logic [15:0] data_out,
    input  wire logic [1:0]  stall,
    output logic             ready,
    output logic [15:0]      data_in,
    output logic [15:0]      last_wdata
);
    logic [2:0] hold     = 3'h0;
    initial ready = 1'b1;
    initial data_in = 16'h0000;
    initial last_wdata = 16'h0000;
    always @(posedge clk_sys) begin
        // Released bus toggles so stale data never reads as valid
        data_in <= !rd_n ? (addr[15:0] ^ 16'ha5a5) : ~data_in;
        if (!wr_n) begin
            last_wdata <= data_out;
        end
        // Stall decided from the address phase; the ready synchroniser needs the lead
        if (ale && stall != 2'h0) begin
            ready <= 1'b0;
            hold  <= {stall, 1'b0} - 3'h1;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end else begin
            ready <= 1'b1;
        end
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the bus sequencer with a memory model.
// Assumes the package, the sequencer and the model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic        clk_sys   = 1'b0;
    logic        rst       = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [19:0] req_addr  = 20'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [2:0]  req_select = 3'h0;
    logic [23:0] cfg       = 24'h000000;
    logic [1:0]  stall     = 2'h0;
    logic        req_ready, rsp_valid, clock_output, ale, rd_n, wr_n, data_oe, hbe_n, fetch, ready;
    logic [15:0] rsp_rdata, data_out, data_in, last_wdata;
    logic [5:0]  chip_select_n;
    logic [19:0] addr;
    int          err_count = 0;
    int          tests_run = 0;

    always #5 clk_sys = ~clk_sys;

    dbdc_bus dbdc_bus_fetch_indicator (.clk_sys, .rst, .req_valid, .req_ready, .req_write, .req_addr,
        .req_wdata, .req_high_byte(req_addr[0]), .req_fetch(!req_write), .req_select,
        .per_select_bus_config(cfg), .rsp_valid, .rsp_rdata, .clock_output, .ale, .rd_n,
        .wr_n, .chip_select_n, .addr, .data_out, .data_oe, .data_in,
        .high_byte_enable_n(hbe_n), .fetch_indicator(fetch), .ready);
    dbdc_mem dbdc_mem_fetch_indicator (.clk_sys, .ale, .rd_n, .wr_n, .addr, .data_out, .stall, .ready,
        .data_in, .last_wdata);

    // One whole transfer; extra is deferral plus wait states, in states
    task automatic do_cycle(input logic wr, input logic [2:0] sel, input int extra,
                            input logic [15:0] a);
        int n;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = wr;
        req_select = sel;
        req_addr = {4'h3, a};
        req_wdata = ~a;
        do @(posedge clk_sys); while (req_ready !== 1'b1);
        @(negedge clk_sys);
        req_valid = 1'b0;
        n = 1;
        while (rsp_valid !== 1'b1 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        // A timed-out wait leaves the response low and counts as a mismatch
        `CHK("response", 1'b1, rsp_valid)
        `CHK("select", ~(6'h01 << sel), chip_select_n)
        `CHK("addr", {4'h3, a}, addr)
        `CHK("high byte", ~a[0], hbe_n)
        `CHK("fetch", ~wr, fetch)
        `CHK("drive", wr, data_oe)
        if (stall != 2'h0) `CHK("stretched", 1'b1, n > 4 + 2 * extra)
        else `CHK("length", 4 + 2 * extra, n)
        if (wr) `CHK("wdata", ~a, last_wdata)
        else `CHK("rdata", a ^ 16'ha5a5, rsp_rdata)
    endtask

    task automatic test_defer;
        do_cycle(1'b0, 3'h0, 1, 16'h0010);
        do_cycle(1'b0, 3'h0, 0, 16'h0013);
        do_cycle(1'b1, 3'h0, 1, 16'h0014);
        do_cycle(1'b1, 3'h0, 0, 16'h0016);
        do_cycle(1'b0, 3'h2, 1, 16'h0018);
        do_cycle(1'b1, 3'h4, 1, 16'h001a);
        $display("test_defer done");
    endtask

    task automatic test_waits;
        @(negedge clk_sys);
        cfg = 24'hf00020;
        do_cycle(1'b0, 3'h1, 3, 16'h0100);
        do_cycle(1'b0, 3'h1, 2, 16'h0102);
        do_cycle(1'b1, 3'h5, 16, 16'h0104);
        do_cycle(1'b0, 3'h5, 15, 16'h0106);
        do_cycle(1'b0, 3'h6, 1, 16'h0108);
        $display("test_waits done");
    endtask

    task automatic test_ready;
        @(negedge clk_sys);
        cfg = 24'h001000;
        stall = 2'h2;
        do_cycle(1'b0, 3'h3, 2, 16'h0200);
        stall = 2'h1;
        do_cycle(1'b1, 3'h3, 2, 16'h0202);
        stall = 2'h0;
        do_cycle(1'b0, 3'h3, 1, 16'h0204);
        $display("test_ready done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        test_defer;
        test_waits;
        test_ready;
        report_and_stop;
    end

    // Whole run is a few hundred cycles; this is far beyond it
    initial begin
        #300000;
        err_count++;
        report_and_stop;
    end
endmodule

bind dbdc_bus dbdc_bus_props dbdc_bus_props_fetch_indicator (.clk_sys, .rst, .req_valid, .req_ready,
    .req_write, .req_select, .per_select_bus_config, .rsp_valid, .clock_output, .ale,
    .rd_n, .wr_n, .ready);
